// >>> shared/crs_pkg.sv
// package: constants and types of the core reset, sleep and stack block
// ==========================================
package crs_pkg;
  localparam int          PC_W            = 13;
  localparam int          DEPTH8          = 8;
  localparam int          DEPTH2          = 2;
  localparam int          SP_W            = 3;
  localparam int          OSC_PER_CYC     = 4;
  localparam int          CLK_NS          = 10;
  localparam int          WDT_BASE_MS     = 18;
  localparam int          CYC_NS          = CLK_NS * OSC_PER_CYC;
  localparam int          WDT_BASE_CYC    = (WDT_BASE_MS * 1000000 + CYC_NS / 2) / CYC_NS;
  localparam int          WDT_W           = 20;
  localparam int          PRE_W           = 8;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR   = 13'h0004;
  localparam logic [7:0]  ACC_RST         = 8'h00;
  localparam int          N_IRQ           = 7;

  typedef enum logic [1:0] {
    CRS_CAUSE_POR,
    CRS_CAUSE_MASTER_CLEAR_PIN,
    CRS_CAUSE_WDT,
    CRS_CAUSE_WAKE
  } crs_cause_type;

  typedef struct packed {
    logic            call_op;
    logic            irq_take;
    logic            ret_lit;
    logic            ret_plain;
    logic            ret_int;
    logic            sleep_op;
    logic            clrwdt_op;
    logic [PC_W-1:0] pc;
  } crs_instr_type;

  typedef struct packed {
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            overflow;
    logic            underflow;
  } crs_stack_out_type;
endpackage

// >>> logic/crs_stack.sv
// return address stack with wrap, overflow and underflow handling
`timescale 1ns/1ps
`default_nettype none
module crs_stack
#(
  parameter int DEPTH = 8,
  parameter bit DEEP  = 1'b1
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    clr,
  input  wire logic                    step,
  // operations
  input  wire logic                    push,
  input  wire logic                    pop,
  input  wire logic [crs_pkg::PC_W-1:0] push_value,
  // results
  output var crs_pkg::crs_stack_out_type res
);
  import crs_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [SP_W-1:0]            sp;
    logic [SP_W:0]              cnt;
    logic [PC_W-1:0]            last_pop;
    logic                       quiet;
  } crs_stk_state_type;

  crs_stk_state_type st_ff;
  crs_stk_state_type nxt_st;
  crs_stack_out_type nxt_res;

  localparam logic [SP_W-1:0] SP_MAX = SP_W'(DEPTH - 1);
  localparam logic [SP_W:0]   CNT_MAX = (SP_W+1)'(DEPTH);

  always_comb begin
    nxt_st  = st_ff;
    nxt_res = '0;
    if (step && push) begin
      nxt_st.mem[st_ff.sp] = push_value;
      nxt_st.sp = (st_ff.sp == SP_MAX) ? '0 : st_ff.sp + 1'b1;
      if (st_ff.cnt == CNT_MAX) begin
        nxt_res.overflow = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
      nxt_st.quiet = 1'b0;
    end else if (step && pop) begin
      nxt_res.pc_load = 1'b1;
      if (st_ff.cnt != '0) begin
        nxt_st.sp = (st_ff.sp == '0) ? SP_MAX : st_ff.sp - 1'b1;
        nxt_st.cnt = st_ff.cnt - 1'b1;
        nxt_res.pc_value = st_ff.mem[nxt_st.sp];
        nxt_st.last_pop = nxt_res.pc_value;
      end else if (DEEP) begin
        // empty: pointer goes to top of a full stack, next pop is silent
        nxt_res.underflow = !st_ff.quiet;
        nxt_st.sp = SP_MAX;
        nxt_st.quiet = 1'b1;
        nxt_res.pc_value = st_ff.mem[SP_MAX];
      end else begin
        nxt_res.underflow = 1'b1;
        nxt_res.pc_value = st_ff.last_pop;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      st_ff <= '0;
      res   <= '0;
    end else begin
      st_ff <= nxt_st;
      res   <= nxt_res;
    end
  end
endmodule
`default_nettype wire

// >>> logic/crs_core.sv
// core reset, sleep, watchdog and return stack control
`timescale 1ns/1ps
`default_nettype none
module crs_core (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // pins and fuses
  input  wire logic                     master_clear_pin,
  input  wire logic                     wdt_fuse_en,
  input  wire logic                     stack_deep,
  // option register prescale select, 0 means one
  input  wire logic [2:0]               wdt_prescale_sel,
  input  wire logic                     wdt_prescale_to_wdt,
  // instruction stream
  input  wire crs_pkg::crs_instr_type   instr,
  // interrupt sources and enable
  input  wire logic                     rb_change_irq,
  input  wire logic                     external_interrupt_pin_irq,
  input  wire logic                     timer0_irq,
  input  wire logic                     second_timer_irq,
  input  wire logic                     timer2_irq,
  input  wire logic                     sync_serial_port_irq,
  input  wire logic                     parallel_port_irq,
  input  wire logic [crs_pkg::N_IRQ-1:0] irq_enable,
  input  wire logic                     global_irq_en,
  // accumulator write from the datapath only
  input  wire logic                     acc_we,
  input  wire logic [7:0]               acc_wdata,
  // outputs
  output logic                          cyc_en,
  output logic                          core_reset,
  output logic                          asleep,
  output logic                          pc_load,
  output logic [crs_pkg::PC_W-1:0]      pc_value,
  output logic                          timeout_flag,
  output logic                          powerdown_flag,
  output logic                          stack_overflow,
  output logic                          stack_underflow,
  output logic [7:0]                    acc_value,
  output var crs_pkg::crs_cause_type     reset_cause
);
  import crs_pkg::*;

  // ==========================================
  // state
  typedef struct packed {
    logic [1:0]       phase;
    logic             master_clear_pin_d;
    logic             master_clear_pin_seen_low;
    logic             asleep;
    logic [WDT_W-1:0] wdt;
    logic [PRE_W-1:0] pre;
    logic             to_n;
    logic             pd_n;
    logic             rst;
    logic             cyc_en;
    logic             pc_load;
    logic [PC_W-1:0]  pc_value;
    logic [7:0]       acc;
    crs_cause_type    cause;
  } crs_state_type;

  crs_state_type     st_ff;
  crs_state_type     nxt_st;
  crs_stack_out_type s2_res;
  crs_stack_out_type s8_res;
  logic              stk_clr;
  logic              do_push;
  logic              pop2;
  logic              pop8;
  logic [N_IRQ-1:0]  irq_vec;
  logic              irq_wake;
  logic              wdt_tick;
  logic [PRE_W-1:0]  pre_lim;

  // enabled interrupt sources, able to wake the core from sleep
  assign irq_vec  = {parallel_port_irq, sync_serial_port_irq, timer2_irq, second_timer_irq,
                     timer0_irq, external_interrupt_pin_irq, rb_change_irq} & irq_enable;
  assign irq_wake = |irq_vec;
  assign pre_lim  = wdt_prescale_to_wdt ? PRE_W'((1 << wdt_prescale_sel) - 1) : '0;
  assign wdt_tick = st_ff.cyc_en && (st_ff.pre == pre_lim);
  assign stk_clr  = srst || st_ff.rst;
  assign do_push  = !st_ff.asleep && (instr.call_op || instr.irq_take);
  assign pop2     = instr.ret_lit;
  assign pop8     = instr.ret_lit || instr.ret_plain || instr.ret_int;

  // ==========================================
  // stacks, only the selected one is used
  crs_stack #(.DEPTH(DEPTH2), .DEEP(1'b0)) u_stack2 (
    .core_clk   (core_clk),
    .clr        (stk_clr),
    .step       (st_ff.cyc_en && !stack_deep && !st_ff.asleep),
    .push       (do_push),
    .pop        (pop2),
    .push_value (PC_W'(instr.pc + 1'b1)),
    .res        (s2_res)
  );

  crs_stack #(.DEPTH(DEPTH8), .DEEP(1'b1)) u_stack8 (
    .core_clk   (core_clk),
    .clr        (stk_clr),
    .step       (st_ff.cyc_en && stack_deep && !st_ff.asleep),
    .push       (do_push),
    .pop        (pop8),
    .push_value (PC_W'(instr.pc + 1'b1)),
    .res        (s8_res)
  );

  // ==========================================
  // next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.phase    = st_ff.phase + 1'b1;
    nxt_st.cyc_en   = (st_ff.phase == 2'(OSC_PER_CYC - 2));
    nxt_st.master_clear_pin_d   = master_clear_pin;
    nxt_st.rst      = 1'b0;
    nxt_st.pc_load  = 1'b0;
    if (!master_clear_pin) begin
      nxt_st.master_clear_pin_seen_low = 1'b1;
    end
    if (stack_deep ? s8_res.pc_load : s2_res.pc_load) begin
      nxt_st.pc_load  = 1'b1;
      nxt_st.pc_value = stack_deep ? s8_res.pc_value : s2_res.pc_value;
    end
    if (acc_we && !st_ff.asleep) begin
      nxt_st.acc = acc_wdata;
    end
    if (st_ff.cyc_en) begin
      // prescaler then watchdog, only with the fuse set
      if (wdt_fuse_en) begin
        nxt_st.pre = wdt_tick ? '0 : st_ff.pre + 1'b1;
        if (wdt_tick) begin
          nxt_st.wdt = st_ff.wdt + 1'b1;
        end
      end
      if (instr.clrwdt_op && !st_ff.asleep) begin
        nxt_st.wdt = '0;
        nxt_st.pre = '0;
        nxt_st.to_n = 1'b1;
        nxt_st.pd_n = 1'b1;
      end
      if (instr.sleep_op && !st_ff.asleep) begin
        nxt_st.asleep = 1'b1;
        nxt_st.pd_n   = 1'b0;
        nxt_st.to_n   = 1'b1;
        nxt_st.wdt    = '0;
        nxt_st.pre    = '0;
      end
      if (wdt_fuse_en && wdt_tick && st_ff.wdt == WDT_W'(WDT_BASE_CYC - 1)) begin
        nxt_st.wdt  = '0;
        nxt_st.pre  = '0;
        nxt_st.to_n = 1'b0;
        if (st_ff.asleep) begin
          nxt_st.asleep = 1'b0;
          nxt_st.cause  = CRS_CAUSE_WAKE;
          nxt_st.pc_load  = 1'b1;
          nxt_st.pc_value = PC_W'(instr.pc + 1'b1);
        end else begin
          nxt_st.rst   = 1'b1;
          nxt_st.cause = CRS_CAUSE_WDT;
        end
      end else if (st_ff.asleep && irq_wake) begin
        nxt_st.asleep = 1'b0;
        nxt_st.cause  = CRS_CAUSE_WAKE;
        nxt_st.pc_load  = 1'b1;
        // with global enable the core vectors, otherwise it resumes
        nxt_st.pc_value = global_irq_en ? INT_VECTOR : PC_W'(instr.pc + 1'b1);
      end
    end
    // release of master clear after a low level
    if (st_ff.master_clear_pin_seen_low && master_clear_pin && !st_ff.master_clear_pin_d) begin
      nxt_st.master_clear_pin_seen_low = 1'b0;
      nxt_st.rst      = 1'b1;
      nxt_st.cause    = CRS_CAUSE_MASTER_CLEAR_PIN;
      nxt_st.to_n     = 1'b1;
      nxt_st.pd_n     = st_ff.asleep ? 1'b0 : st_ff.pd_n;
      nxt_st.asleep   = 1'b0;
    end
    if (nxt_st.rst) begin
      nxt_st.wdt      = '0;
      nxt_st.pre      = '0;
      nxt_st.asleep   = 1'b0;
      nxt_st.pc_load  = 1'b1;
      nxt_st.pc_value = RESET_VECTOR;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // power-on values
      st_ff          <= '0;
      st_ff.to_n     <= 1'b1;
      st_ff.pd_n     <= 1'b1;
      st_ff.master_clear_pin_d   <= 1'b1;
      st_ff.acc      <= ACC_RST;
      st_ff.cause    <= CRS_CAUSE_POR;
      st_ff.pc_value <= RESET_VECTOR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stack_overflow  <= 1'b0;
      stack_underflow <= 1'b0;
    end else begin
      stack_overflow  <= stack_deep ? s8_res.overflow : s2_res.overflow;
      stack_underflow <= stack_deep ? s8_res.underflow : s2_res.underflow;
    end
  end

  assign cyc_en         = st_ff.cyc_en;
  assign core_reset     = st_ff.rst;
  assign asleep         = st_ff.asleep;
  assign pc_load        = st_ff.pc_load;
  assign pc_value       = st_ff.pc_value;
  assign timeout_flag   = st_ff.to_n;
  assign powerdown_flag = st_ff.pd_n;
  assign acc_value      = st_ff.acc;
  assign reset_cause    = st_ff.cause;
endmodule
`default_nettype wire

// >>> bench/crs_core_checker.sv
// checker: timing relations on the core control ports
`timescale 1ns/1ps
`default_nettype none
module crs_core_checker (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      srst,
  // stimulus
  input wire logic                      master_clear_pin,
  input wire logic                      stack_deep,
  input wire crs_pkg::crs_instr_type    instr,
  input wire logic                      second_timer_irq,
  input wire logic [crs_pkg::N_IRQ-1:0] irq_enable,
  input wire logic                      global_irq_en,
  // responses
  input wire logic                      cyc_en,
  input wire logic                      core_reset,
  input wire logic                      asleep,
  input wire logic                      pc_load,
  input wire logic [crs_pkg::PC_W-1:0]  pc_value,
  input wire logic                      timeout_flag,
  input wire logic                      powerdown_flag,
  input wire logic                      stack_overflow,
  input wire logic                      stack_underflow,
  input wire crs_pkg::crs_cause_type    reset_cause
);
  import crs_pkg::*;
  // ==========================================
  // helpers
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // a lone return: awake, pin released, no push competing for the slot
  wire ret_ok = cyc_en && !asleep && master_clear_pin && !instr.call_op && !instr.irq_take;
  wire push_req = instr.call_op || instr.irq_take;
  wire pop_req = instr.ret_lit || instr.ret_plain || instr.ret_int;
  sequence s_call_ret;
    (cyc_en && !asleep && master_clear_pin && instr.call_op) ##8 (ret_ok && instr.ret_lit);
  endsequence
  // ==========================================
  // properties
  a_cyc_spacing: assert property (cyc_en |=> !cyc_en [*3])
    else $error("instruction strobe closer than four clocks");
  a_por_flags: assert property ($fell(srst) |-> timeout_flag && powerdown_flag && !asleep
    && reset_cause == CRS_CAUSE_POR) else $error("bad values after power-on reset");
  a_sleep_entry: assert property (ret_ok && instr.sleep_op |=> asleep && !powerdown_flag)
    else $error("sleep not entered");
  a_lit_pop: assert property (ret_ok && instr.ret_lit |-> ##2 pc_load)
    else $error("literal return gave no load");
  a_deep_pop: assert property (ret_ok && stack_deep && (instr.ret_plain || instr.ret_int) |-> ##2 pc_load)
    else $error("deep stack return gave no load");
  a_shallow_hold: assert property (ret_ok && !stack_deep && (instr.ret_plain || instr.ret_int)
    && !instr.ret_lit |-> ##2 !pc_load) else $error("shallow stack popped on plain return");
  a_pop_value: assert property (s_call_ret |-> ##2 pc_load && pc_value == PC_W'($past(instr.pc, 10) + 1'b1))
    else $error("return address is not call address plus one");
  a_ovf_cause: assert property (stack_overflow |-> $past(cyc_en, 2) && $past(push_req, 2))
    else $error("overflow without a push");
  a_unf_cause: assert property (stack_underflow |-> $past(cyc_en, 2) && $past(pop_req, 2))
    else $error("underflow without a pop");
  a_master_clear_pin_reset: assert property ($rose(master_clear_pin) |=> core_reset && pc_load && pc_value == RESET_VECTOR)
    else $error("pin release gave no reset");
  a_wake_vector: assert property (asleep && cyc_en && global_irq_en && second_timer_irq && irq_enable[3]
    && master_clear_pin |=> !asleep && pc_load && pc_value == INT_VECTOR) else $error("timer wake missed");
endmodule
bind crs_core crs_core_checker i_chk (.core_clk(core_clk), .srst(srst), .master_clear_pin(master_clear_pin),
  .stack_deep(stack_deep), .instr(instr), .second_timer_irq(second_timer_irq), .irq_enable(irq_enable),
  .global_irq_en(global_irq_en), .cyc_en(cyc_en), .core_reset(core_reset), .asleep(asleep), .pc_load(pc_load),
  .pc_value(pc_value), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
  .stack_overflow(stack_overflow), .stack_underflow(stack_underflow), .reset_cause(reset_cause));
`default_nettype wire

// >>> bench/test_core_reset_sleep_stack.sv
// testbench: directed and random stimulus with a queue of expected loads
`timescale 1ns/1ps
`default_nettype none
module test_core_reset_sleep_stack;
  import crs_pkg::*;
  // ==========================================
  // signals
  logic            core_clk, srst, master_clear_pin_pin, deep, acc_we, to_wdt, cyc_en, core_reset, asleep, pc_load;
  logic            to_flag, pd_flag, ovf, unf;
  logic [2:0]      pre_sel;
  logic [6:0]      irq_src, irq_en;
  logic [7:0]      acc_wdata, acc_value;
  logic [PC_W-1:0] pc_value, p;
  logic [PC_W:0]   n;
  logic [PC_W:0]   notes[$];
  logic [PC_W-1:0] pushed[$];
  crs_instr_type   instr;
  crs_cause_type   cause;
  int              error_cnt = 0, samples_checked = 0, seed = 31, cycles = 0;
  crs_core i_dut (.core_clk(core_clk), .srst(srst), .master_clear_pin(master_clear_pin_pin), .wdt_fuse_en(1'h1),
    .stack_deep(deep), .wdt_prescale_sel(pre_sel), .wdt_prescale_to_wdt(to_wdt), .instr(instr),
    .rb_change_irq(irq_src[0]), .external_interrupt_pin_irq(irq_src[1]), .timer0_irq(irq_src[2]),
    .second_timer_irq(irq_src[3]), .timer2_irq(irq_src[4]), .sync_serial_port_irq(irq_src[5]),
    .parallel_port_irq(irq_src[6]), .irq_enable(irq_en), .global_irq_en(1'h1), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .cyc_en(cyc_en), .core_reset(core_reset), .asleep(asleep), .pc_load(pc_load),
    .pc_value(pc_value), .timeout_flag(to_flag), .powerdown_flag(pd_flag), .stack_overflow(ovf),
    .stack_underflow(unf), .acc_value(acc_value), .reset_cause(cause));
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic d);
    deep <= d;
    srst <= 1'h1;
    repeat (20) @(posedge core_clk);
    srst <= 1'h0;
    pushed.delete();
    @(posedge core_clk);
    #1 check("por state", {to_flag, pd_flag, asleep, cause}, {1'h1, 1'h1, 1'h0, CRS_CAUSE_POR});
  endtask
  // kind 0 call, 1 irq, 2..4 returns, 5 sleep, 6 watchdog clear; e: -1 no load, -2 load of any value
  // overflow and underflow stand for one clock only, two edges after the taking edge
  task automatic op(input int kind, input logic [PC_W-1:0] pc, input int e, input logic ov, input logic un);
    do begin @(posedge core_clk); #1; end while (cyc_en !== 1'h1);
    repeat (4) @(posedge core_clk);
    instr <= crs_instr_type'({7'h40 >> kind, pc});
    if (e != -1) notes.push_back(e == -2 ? {1'h1, 13'h0000} : {1'h0, PC_W'(e)});
    @(posedge core_clk);
    instr <= '0;
    @(posedge core_clk);
    #1 check("overflow", ovf, ov);
    check("underflow", unf, un);
  endtask
  // ==========================================
  // clock, watchdog of the run, load monitor
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 4000) begin
      error_cnt++;
      complete_run();
    end else if (!srst && pc_load === 1'h1) begin
      if (notes.size() == 0) check("unexpected load", 16'h0001, 16'h0000);
      else begin
        n = notes.pop_front();
        if (!n[PC_W]) check("pc_value", pc_value, n[PC_W-1:0]);
      end
    end
  end
  // ==========================================
  // scenarios
  initial begin
    srst = 1'h1;
    master_clear_pin_pin = 1'h1;
    deep = 1'h1;
    acc_we = 1'h0;
    acc_wdata = 8'h00;
    instr = '0;
    irq_src = '0;
    irq_en = 7'h7F;
    pre_sel = 3'($random(seed));
    to_wdt = 1'($random(seed));
    do_reset(1'h1);
    @(posedge core_clk);
    acc_wdata <= 8'($random(seed));
    acc_we <= 1'h1;
    repeat (4) @(posedge core_clk);
    acc_we <= 1'h0;
    @(posedge core_clk);
    #1 check("acc_value", acc_value, acc_wdata);
    // nine pushes overrun eight slots; the ninth must still land
    for (int i = 0; i < 9; i++) begin
      p = PC_W'($random(seed));
      pushed.push_back(p + 1'b1);
      op(i % 2, p, -1, i == 8, 1'h0);
    end
    for (int i = 0; i < 8; i++) op(2 + i % 3, 13'h0000, int'(pushed.pop_back()), 1'h0, 1'h0);
    op(2, 13'h0000, -2, 1'h0, 1'h1);
    op(3, 13'h0000, -2, 1'h0, 1'h0);
    for (int i = 0; i < N_IRQ; i++) begin
      op(5, 13'h0000, -1, 1'h0, 1'h0);
      check("asleep pd", {asleep, pd_flag}, 2'h2);
      @(posedge core_clk);
      irq_src <= 7'h01 << i;
      notes.push_back({1'h0, INT_VECTOR});
      repeat (6) @(posedge core_clk);
      irq_src <= 7'h00;
      #1 check("woken", asleep, 0);
    end
    op(6, 13'h0000, -1, 1'h0, 1'h0);
    check("clrwdt flags", {to_flag, pd_flag}, 2'h3);
    op(5, 13'h0000, -1, 1'h0, 1'h0);
    // a masked source must leave the core asleep
    @(posedge core_clk);
    irq_en <= 7'h77;
    irq_src <= 7'h08;
    repeat (6) @(posedge core_clk);
    irq_src <= 7'h00;
    irq_en <= 7'h7F;
    #1 check("masked wake", asleep, 1'h1);
    @(posedge core_clk);
    master_clear_pin_pin <= 1'h0;
    notes.push_back({1'h0, RESET_VECTOR});
    repeat (2) @(posedge core_clk);
    master_clear_pin_pin <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1 check("master_clear_pin cause", {asleep, to_flag, pd_flag, cause}, {1'h0, 1'h1, 1'h0, CRS_CAUSE_MASTER_CLEAR_PIN});
    @(posedge core_clk);
    do_reset(1'h0);
    for (int i = 0; i < 3; i++) begin
      p = PC_W'($random(seed));
      pushed.push_back(p + 1'b1);
      op(0, p, -1, i == 2, 1'h0);
    end
    op(3, 13'h0000, -1, 1'h0, 1'h0);
    op(4, 13'h0000, -1, 1'h0, 1'h0);
    op(2, 13'h0000, int'(pushed.pop_back()), 1'h0, 1'h0);
    p = pushed.pop_back();
    op(2, 13'h0000, int'(p), 1'h0, 1'h0);
    op(2, 13'h0000, int'(p), 1'h0, 1'h1);
    repeat (4) @(posedge core_clk);
    check("notes left", 16'(notes.size()), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
